// *** heater_alarm_pkg.sv ***
// Package for the heater current alarm block: scaling, limits, timing.
// Assumes currents arrive as unsigned tenths of an ampere.
package heater_alarm_pkg;
    localparam int          CUR_W          = 16;
    // Current values in units of 0.1 A
    localparam logic [15:0] THR_ZERO       = 16'h0000;  // 0.0 A
    localparam logic [15:0] THR_FULL       = 16'h01F4;  // 50.0 A
    localparam logic [15:0] MON_MAX        = 16'h0226;  // 55.0 A
    localparam logic [15:0] SAT_CODE       = 16'hFFFF;
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          MIN_ON_MS      = 100;
    localparam int          MIN_ON_CYC     = (CLK_HZ / 1000) * MIN_ON_MS;
    localparam int          FLASH_MS       = 250;
    localparam int          FLASH_CYC      = (CLK_HZ / 1000) * FLASH_MS;

    typedef struct packed {
        logic [15:0] burnout_thr;
        logic [15:0] overcur_thr;
    } chan_cfg_t;

    typedef struct packed {
        logic        underload_alarm;
        logic        overcur_alarm;
        logic [15:0] monitor;
        logic        monitor_valid;
    } chan_stat_t;
endpackage

// *** heater_chan.sv ***
// One current channel: compares a sampled reading against its thresholds.
// Assumes i_sample pulses at the end of a qualifying on-time with data.
`timescale 1ns/1ns
module heater_chan
    import heater_alarm_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_enable,
    input  wire logic        i_sample,
    input  wire logic [15:0] i_current,
    input  wire chan_cfg_t   i_cfg,
    output chan_stat_t       o_stat
);
    chan_stat_t stat_ff;
    chan_stat_t nxt_stat;

    always_comb begin
        nxt_stat = stat_ff;
        if (!i_enable) begin
            nxt_stat = '0;
        end else if (i_sample) begin
            // Zero threshold can never be undercut, so alarm stays off
            nxt_stat.underload_alarm = (i_current < i_cfg.burnout_thr) ||
                (i_cfg.burnout_thr >= THR_FULL);
            // Full-scale threshold disables, zero threshold forces on
            nxt_stat.overcur_alarm = (i_cfg.overcur_thr < THR_FULL) &&
                ((i_current > i_cfg.overcur_thr) ||
                 (i_cfg.overcur_thr == THR_ZERO));
            nxt_stat.monitor = (i_current > MON_MAX) ? SAT_CODE
                                                     : i_current;
            nxt_stat.monitor_valid = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            stat_ff <= '0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign o_stat = stat_ff;
endmodule

// *** heater_current_alarm.sv ***
// Heater current alarm: two current channels, on-time qualifying, lamp
// and display flash. Assumes a converter delivers current readings in
// tenths of an ampere, synchronous to the core clock.
`timescale 1ns/1ns
module heater_current_alarm
    import heater_alarm_pkg::*;
#(
    parameter int NUM_CH     = 2,
    parameter int MIN_ON     = MIN_ON_CYC,
    parameter int FLASH_HALF = FLASH_CYC
)
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_heat_out,
    input  wire logic [15:0] i_current_sense_input_1,
    input  wire logic [15:0] i_current_sense_input_2,
    input  wire logic        i_cfg_load,
    input  wire logic [15:0] i_burnout_thr_1,
    input  wire logic [15:0] i_overcur_thr_1,
    input  wire logic [15:0] i_burnout_thr_2,
    input  wire logic [15:0] i_overcur_thr_2,
    input  wire logic        i_alarm1_assigned,
    input  wire logic        i_burnout_detect_enable,
    input  wire logic        i_overcur_use_enable,
    output logic             o_underload_alarm_1,
    output logic             o_overcur_alarm_1,
    output logic             o_underload_alarm_2,
    output logic             o_overcur_alarm_2,
    output logic [15:0]      o_monitor_1,
    output logic [15:0]      o_monitor_2,
    output logic             o_heater_alarm_lamp,
    output logic             o_display_flash_1,
    output logic             o_display_flash_2
);
    // Refuse sizes that the counters and the channel array cannot serve
    if (NUM_CH < 1 || NUM_CH > 2 ||
        MIN_ON < 1 || FLASH_HALF < 1) begin : g_bad_param
        $error("heater_current_alarm: unsupported parameters");
    end

    localparam int ONW = $clog2(MIN_ON + 2);
    localparam int FLW = $clog2(FLASH_HALF + 1);

    chan_cfg_t  cfg_ff   [2];
    chan_cfg_t  nxt_cfg  [2];
    chan_stat_t stat     [2];
    logic [15:0] cur     [2];

    logic [ONW-1:0] on_cnt_ff;
    logic [ONW-1:0] nxt_on_cnt;
    logic           heat_d_ff;
    logic           nxt_heat_d;
    logic           sample;
    logic           mon_en;

    logic [FLW-1:0] fl_cnt_ff;
    logic [FLW-1:0] nxt_fl_cnt;
    logic           blink_ff;
    logic           nxt_blink;

    logic           underload1_ff;
    logic           nxt_underload1;
    logic           overcur1_ff;
    logic           nxt_overcur1;
    logic           underload2_ff;
    logic           nxt_underload2;
    logic           overcur2_ff;
    logic           nxt_overcur2;
    logic           lamp_ff;
    logic           nxt_lamp;
    logic           flash1_ff;
    logic           nxt_flash1;
    logic           flash2_ff;
    logic           nxt_flash2;
    logic           alarm1_any;
    logic           alarm2_any;
    logic [15:0]    mon1_ff;
    logic [15:0]    nxt_mon1;
    logic [15:0]    mon2_ff;
    logic [15:0]    nxt_mon2;

    assign cur[0] = i_current_sense_input_1;
    assign cur[1] = i_current_sense_input_2;

    assign mon_en = i_alarm1_assigned &&
        (i_burnout_detect_enable || i_overcur_use_enable);

    // Thresholds above full scale are clamped rather than refused
    function automatic logic [15:0] clamp(input logic [15:0] v);
        clamp = (v > THR_FULL) ? THR_FULL : v;
    endfunction

    always_comb begin
        nxt_cfg[0] = cfg_ff[0];
        nxt_cfg[1] = cfg_ff[1];
        if (i_cfg_load) begin
            nxt_cfg[0].burnout_thr = clamp(i_burnout_thr_1);
            nxt_cfg[0].overcur_thr = clamp(i_overcur_thr_1);
            nxt_cfg[1].burnout_thr = clamp(i_burnout_thr_2);
            nxt_cfg[1].overcur_thr = clamp(i_overcur_thr_2);
        end
    end

    // On-time counter saturates just past the minimum
    always_comb begin
        nxt_heat_d = i_heat_out;
        nxt_on_cnt = on_cnt_ff;
        if (i_heat_out) begin
            if (on_cnt_ff <= ONW'(MIN_ON)) begin
                nxt_on_cnt = on_cnt_ff + ONW'(1);
            end
        end else begin
            nxt_on_cnt = '0;
        end
    end

    // Sample at pulse end only if on-time exceeded the minimum
    assign sample = heat_d_ff && !i_heat_out &&
                    (on_cnt_ff > ONW'(MIN_ON));

    always_comb begin
        nxt_blink  = blink_ff;
        nxt_fl_cnt = fl_cnt_ff + FLW'(1);
        if (fl_cnt_ff >= FLW'(FLASH_HALF - 1)) begin
            nxt_fl_cnt = '0;
            nxt_blink  = !blink_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            heater_chan u_chan (
                .i_core_clk (i_core_clk),
                .i_rst_b    (i_rst_b),
                .i_enable   (mon_en && (g < NUM_CH)),
                .i_sample   (sample),
                .i_current  (cur[g]),
                .i_cfg      (cfg_ff[g]),
                .o_stat     (stat[g])
            );
        end
    endgenerate

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cfg_ff[0]  <= '{burnout_thr: THR_ZERO,
                           overcur_thr: THR_FULL};
            cfg_ff[1]  <= '{burnout_thr: THR_ZERO,
                           overcur_thr: THR_FULL};
            on_cnt_ff  <= '0;
            heat_d_ff  <= 1'b0;
            fl_cnt_ff  <= '0;
            blink_ff   <= 1'b0;
        end else begin
            cfg_ff[0]  <= nxt_cfg[0];
            cfg_ff[1]  <= nxt_cfg[1];
            on_cnt_ff  <= nxt_on_cnt;
            heat_d_ff  <= nxt_heat_d;
            fl_cnt_ff  <= nxt_fl_cnt;
            blink_ff   <= nxt_blink;
        end
    end

    // Per-channel alarm summary feeds the shared lamp and the flash gates
    assign alarm1_any = stat[0].underload_alarm || stat[0].overcur_alarm;
    assign alarm2_any = stat[1].underload_alarm || stat[1].overcur_alarm;

    always_comb begin
        nxt_underload1 = stat[0].underload_alarm;
        nxt_overcur1   = stat[0].overcur_alarm;
        nxt_underload2 = stat[1].underload_alarm;
        nxt_overcur2   = stat[1].overcur_alarm;
        nxt_mon1       = stat[0].monitor;
        nxt_mon2       = stat[1].monitor;
        // Lamp is shared; each display flashes only for its own channel
        nxt_lamp       = alarm1_any || alarm2_any;
        nxt_flash1     = blink_ff && alarm1_any;
        nxt_flash2     = blink_ff && alarm2_any;
    end

    // Output stage: every port comes from a flip-flop
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            underload1_ff <= 1'b0;
            overcur1_ff   <= 1'b0;
            underload2_ff <= 1'b0;
            overcur2_ff   <= 1'b0;
            mon1_ff       <= THR_ZERO;
            mon2_ff       <= THR_ZERO;
            lamp_ff       <= 1'b0;
            flash1_ff     <= 1'b0;
            flash2_ff     <= 1'b0;
        end else begin
            underload1_ff <= nxt_underload1;
            overcur1_ff   <= nxt_overcur1;
            underload2_ff <= nxt_underload2;
            overcur2_ff   <= nxt_overcur2;
            mon1_ff       <= nxt_mon1;
            mon2_ff       <= nxt_mon2;
            lamp_ff       <= nxt_lamp;
            flash1_ff     <= nxt_flash1;
            flash2_ff     <= nxt_flash2;
        end
    end

    assign o_underload_alarm_1 = underload1_ff;
    assign o_overcur_alarm_1   = overcur1_ff;
    assign o_underload_alarm_2 = underload2_ff;
    assign o_overcur_alarm_2   = overcur2_ff;
    assign o_monitor_1         = mon1_ff;
    assign o_monitor_2         = mon2_ff;
    assign o_heater_alarm_lamp = lamp_ff;
    assign o_display_flash_1   = flash1_ff;
    assign o_display_flash_2   = flash2_ff;
endmodule

// *** heater_current_alarm_sva.sv ***
// Checker for the heater current alarm: lamp, flash, clear and hold.
// Assumes it is bound into heater_current_alarm and shares its MIN_ON.
`timescale 1ns/1ns
module heater_current_alarm_chk
    import heater_alarm_pkg::*;
#(parameter int MIN_ON = 10)
(
    input wire logic        i_core_clk,
    input wire logic        i_rst_b,
    input wire logic        i_heat_out,
    input wire logic        i_alarm1_assigned,
    input wire logic        i_burnout_detect_enable,
    input wire logic        i_overcur_use_enable,
    input wire logic        o_underload_alarm_1,
    input wire logic        o_overcur_alarm_1,
    input wire logic        o_underload_alarm_2,
    input wire logic        o_overcur_alarm_2,
    input wire logic [15:0] o_monitor_1,
    input wire logic [15:0] o_monitor_2,
    input wire logic        o_heater_alarm_lamp,
    input wire logic        o_display_flash_1,
    input wire logic        o_display_flash_2
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    logic [31:0] on_ff, nxt_on;
    logic [3:0]  age_ff, nxt_age;
    logic        qual_ff, nxt_qual, a1, a2, any, mon_on;
    assign a1 = o_underload_alarm_1 | o_overcur_alarm_1;
    assign a2 = o_underload_alarm_2 | o_overcur_alarm_2;
    assign any = a1 | a2;
    assign mon_on = i_alarm1_assigned
                  & (i_burnout_detect_enable | i_overcur_use_enable);
    // Remember whether the last heating pulse was long enough to count
    always_comb begin
        nxt_on = i_heat_out ? on_ff + 32'h1 : 32'h0;
        nxt_qual = qual_ff;
        nxt_age = (age_ff == 4'hF) ? age_ff : age_ff + 4'h1;
        if (!i_heat_out && on_ff != 32'h0) begin
            nxt_qual = (on_ff > MIN_ON);
            nxt_age = 4'h0;
        end
    end
    always_ff @(posedge i_core_clk) begin
        on_ff <= i_rst_b ? nxt_on : 32'h0;
        age_ff <= i_rst_b ? nxt_age : 4'hF;
        qual_ff <= i_rst_b ? nxt_qual : 1'b0;
    end
    sequence s_off;
        !mon_on ##1 !mon_on;
    endsequence
    property p_off;
        s_off |=> !any && o_monitor_1 == 16'h0000
                       && o_monitor_2 == 16'h0000;
    endproperty
    // A new reading shows exactly two edges after the qualifying pulse end
    property p_hold;
        $changed(o_monitor_1) && mon_on && $past(mon_on, 4)
            |-> qual_ff && age_ff == 4'h1;
    endproperty
    property p_lamp_on;
        any |-> o_heater_alarm_lamp;
    endproperty
    property p_lamp_off;
        !any |-> !o_heater_alarm_lamp;
    endproperty
    property p_flash_1;
        o_display_flash_1 |-> a1;
    endproperty
    property p_flash_2;
        o_display_flash_2 |-> a2;
    endproperty
    property p_range_1;
        o_monitor_1 <= MON_MAX || o_monitor_1 == SAT_CODE;
    endproperty
    property p_range_2;
        o_monitor_2 <= MON_MAX || o_monitor_2 == SAT_CODE;
    endproperty
    a_off: assert property (p_off)
        else $error("status not cleared");
    a_hold: assert property (p_hold)
        else $error("reading not from a qualifying pulse");
    a_lamp_on: assert property (p_lamp_on)
        else $error("lamp dark");
    a_lamp_off: assert property (p_lamp_off)
        else $error("lamp lit");
    a_flash_1: assert property (p_flash_1)
        else $error("flash 1");
    a_flash_2: assert property (p_flash_2)
        else $error("flash 2");
    a_range_1: assert property (p_range_1)
        else $error("monitor 1");
    a_range_2: assert property (p_range_2)
        else $error("monitor 2");
endmodule

bind heater_current_alarm heater_current_alarm_chk #(
    .MIN_ON (MIN_ON)
) u_chk (
    .i_core_clk              (i_core_clk),
    .i_rst_b                 (i_rst_b),
    .i_heat_out              (i_heat_out),
    .i_alarm1_assigned       (i_alarm1_assigned),
    .i_burnout_detect_enable (i_burnout_detect_enable),
    .i_overcur_use_enable    (i_overcur_use_enable),
    .o_underload_alarm_1     (o_underload_alarm_1),
    .o_overcur_alarm_1       (o_overcur_alarm_1),
    .o_underload_alarm_2     (o_underload_alarm_2),
    .o_overcur_alarm_2       (o_overcur_alarm_2),
    .o_monitor_1             (o_monitor_1),
    .o_monitor_2             (o_monitor_2),
    .o_heater_alarm_lamp     (o_heater_alarm_lamp),
    .o_display_flash_1       (o_display_flash_1),
    .o_display_flash_2       (o_display_flash_2)
);

// *** ct_model.sv ***
// Current transformer model: reports the load current while heating.
// Assumes the reading is only held a few cycles after heating stops.
`timescale 1ns/1ns
module ct_model
(
    input  wire logic        i_core_clk,
    input  wire logic        i_heat,
    input  wire logic [15:0] i_load,
    output logic [15:0]      o_current
);
    logic [2:0] hold_ff;
    always_ff @(posedge i_core_clk) begin
        hold_ff <= i_heat ? 3'h4 : (hold_ff == 3'h0 ? 3'h0 : hold_ff - 3'h1);
    end
    // Stale reading is inverted so a late sample cannot match by luck
    assign o_current = (i_heat || hold_ff != 3'h0) ? i_load : ~i_load;
endmodule

// *** testbench.sv ***
// Testbench for heater_current_alarm with two transformer models.
// Assumes shortened MIN_ON and FLASH_HALF so each pulse is brief.
`timescale 1ns/1ns
module testbench;
    import heater_alarm_pkg::*;
    localparam int MON = 10;
    logic        i_core_clk, i_rst_b, i_heat_out, i_cfg_load;
    logic        i_alarm1_assigned, i_burnout_detect_enable;
    logic        i_overcur_use_enable, o_underload_alarm_1, o_overcur_alarm_1;
    logic        o_underload_alarm_2, o_overcur_alarm_2, o_heater_alarm_lamp;
    logic        o_display_flash_1, o_display_flash_2;
    logic [15:0] i_current_sense_input_1, i_current_sense_input_2, ld1, ld2;
    logic [15:0] i_burnout_thr_1, i_overcur_thr_1, o_monitor_1, o_monitor_2;
    logic [15:0] i_burnout_thr_2, i_overcur_thr_2;
    int          err_total, total_checks;
    heater_current_alarm #(.MIN_ON(MON), .FLASH_HALF(4)) u_dut (.*);
    ct_model u_ct1 (.i_core_clk(i_core_clk), .i_heat(i_heat_out),
                    .i_load(ld1), .o_current(i_current_sense_input_1));
    ct_model u_ct2 (.i_core_clk(i_core_clk), .i_heat(i_heat_out),
                    .i_load(ld2), .o_current(i_current_sense_input_2));
    task automatic fail(input string msg);
        $display("[FAIL] %0t %s", $time, msg);
        err_total++;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cfg(input logic [15:0] a, b, c, d);
        i_burnout_thr_1 <= a;
        i_overcur_thr_1 <= b;
        i_burnout_thr_2 <= c;
        i_overcur_thr_2 <= d;
        i_cfg_load <= 1'b1;
        @(posedge i_core_clk);
        i_cfg_load <= 1'b0;
    endtask
    task automatic pulse(input int n, input logic [15:0] a, b);
        ld1 <= a;
        ld2 <= b;
        i_heat_out <= 1'b1;
        repeat (n) @(posedge i_core_clk);
        i_heat_out <= 1'b0;
        repeat (8) @(posedge i_core_clk);
    endtask
    task automatic chk(input logic [35:0] e);
        logic [4:0] f1, f2;
        f1 = 5'h00;
        f2 = 5'h00;
        @(negedge i_core_clk);
        total_checks++;
        if ({o_underload_alarm_1, o_overcur_alarm_1, o_underload_alarm_2,
             o_overcur_alarm_2, o_monitor_1, o_monitor_2} !== e)
            fail("status mismatch");
        if (o_heater_alarm_lamp !== (|e[35:32])) fail("lamp mismatch");
        repeat (10) begin
            @(negedge i_core_clk);
            f1 = f1 + o_display_flash_1;
            f2 = f2 + o_display_flash_2;
        end
        if ((f1 > 0 && f1 < 10) !== (e[35] | e[34])) fail("flash 1 wrong");
        if ((f2 > 0 && f2 < 10) !== (e[33] | e[32])) fail("flash 2 wrong");
        @(posedge i_core_clk);
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (5000) @(posedge i_core_clk);
        fail("timeout");
        results();
    end
    initial begin
        err_total = 0;
        total_checks = 0;
        {i_rst_b, i_heat_out, i_cfg_load} = 3'h0;
        {i_alarm1_assigned, i_burnout_detect_enable} = 2'h3;
        i_overcur_use_enable = 1'b1;
        {ld1, ld2, i_burnout_thr_1, i_overcur_thr_1} = 64'h0;
        {i_burnout_thr_2, i_overcur_thr_2} = 32'h0;
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        pulse(MON + 1, 16'h0064, 16'h0064);
        chk({4'h0, 16'h0064, 16'h0064});
        cfg(16'h00C8, 16'h012C, 16'h00C8, 16'h012C);
        pulse(MON + 1, 16'h0096, 16'h015E);
        chk({4'h9, 16'h0096, 16'h015E});
        pulse(MON, 16'h00FA, 16'h00FA);
        chk({4'h9, 16'h0096, 16'h015E});
        pulse(MON + 1, 16'h00C8, 16'h012C);
        chk({4'h0, 16'h00C8, 16'h012C});
        cfg(16'h0000, 16'h01F4, 16'h01F4, 16'h0000);
        pulse(MON + 1, 16'h0227, 16'h0226);
        chk({4'h3, 16'hFFFF, 16'h0226});
        pulse(MON + 1, 16'h0000, 16'h0000);
        chk({4'h3, 16'h0000, 16'h0000});
        i_alarm1_assigned <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        chk(36'h0);
        i_alarm1_assigned <= 1'b1;
        {i_burnout_detect_enable, i_overcur_use_enable} <= 2'h0;
        pulse(MON + 1, 16'h0064, 16'h0064);
        chk(36'h0);
        // Mid-run reset restores default thresholds; one enable suffices
        i_rst_b <= 1'b0;
        {i_burnout_detect_enable, i_overcur_use_enable} <= 2'h2;
        repeat (4) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        pulse(MON + 1, 16'h0064, 16'h0064);
        chk({4'h0, 16'h0064, 16'h0064});
        results();
    end
endmodule
